// >>> bench/rtd_host_model.sv
// host side model issuing register accesses to the time and date block
`timescale 1ns/1ps
module rtd_host_model (
    // clock
    input  wire logic             clk,
    // register access
    output rtd_pkg::rtd_req_s     req,
    input  wire logic [7:0]       rd_data
);
    import rtd_pkg::*;

    int unsigned idle_cycles = 0;

    initial req = '{busy: 1'b0, wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'hff};

    task automatic open_access();
        @(posedge clk);
        req.busy <= 1'b1;
    endtask

    task automatic close_access();
        @(posedge clk);
        req.busy <= 1'b0;
    endtask

    // released lines show the inverse of the last value
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        repeat (idle_cycles) @(posedge clk);
        @(posedge clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr    <= 1'b0;
        req.addr  <= ~a;
        req.wdata <= ~d;
    endtask

    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        repeat (idle_cycles) @(posedge clk);
        @(posedge clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd   <= 1'b0;
        req.addr <= ~a;
        @(posedge clk);
        d = rd_data;
    endtask
endmodule

// >>> bench/tb_rtd_time_date_regs.sv
// self-checking testbench of the time and date register set
`timescale 1ns/1ps
module tb_rtd_time_date_regs;
    import rtd_pkg::*;

    logic      clk         = 1'b0;
    logic      arst_n      = 1'b0;
    logic      tick_1hz    = 1'b0;
    logic      supply_low  = 1'b0;
    logic      osc_stopped = 1'b0;
    rtd_req_s  req;
    logic [7:0] rd_data;
    rtd_time_s time_out;
    logic      tick_pending;
    int        fail_count      = 0;
    int        samples_checked = 0;

    always #4 clk = ~clk;

    rtd_time_date_regs u_rtd_time_date_regs (
        .clk          (clk),
        .arst_n       (arst_n),
        .req          (req),
        .tick_1hz     (tick_1hz),
        .supply_low   (supply_low),
        .osc_stopped  (osc_stopped),
        .rd_data      (rd_data),
        .time_out     (time_out),
        .tick_pending (tick_pending)
    );

    rtd_host_model u_rtd_host_model (
        .clk     (clk),
        .req     (req),
        .rd_data (rd_data)
    );

    task automatic results();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // registers 02h..08h packed high byte first
    task automatic set_regs(input logic [55:0] v);
        u_rtd_host_model.open_access();
        for (int i = 0; i < 7; i++) begin
            u_rtd_host_model.write_byte(RTD_ADDR_SEC + 8'(i), v[55-8*i -: 8]);
        end
        u_rtd_host_model.close_access();
    endtask

    task automatic expect_regs(input logic [55:0] e);
        logic [7:0] v;
        u_rtd_host_model.open_access();
        for (int i = 0; i < 7; i++) begin
            u_rtd_host_model.read_byte(RTD_ADDR_SEC + 8'(i), v);
            check($sformatf("reg %h", RTD_ADDR_SEC + 8'(i)), v, e[55-8*i -: 8]);
        end
        u_rtd_host_model.close_access();
    endtask

    localparam int P_TICK = 0;
    localparam int P_LOW  = 1;
    localparam int P_OSC  = 2;

    // one-cycle pulse on the selected event input
    task automatic pulse(input int sel);
        @(posedge clk);
        tick_1hz    <= (sel == P_TICK);
        supply_low  <= (sel == P_LOW);
        osc_stopped <= (sel == P_OSC);
        @(posedge clk);
        tick_1hz    <= 1'b0;
        supply_low  <= 1'b0;
        osc_stopped <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        check("pending", {7'h0, tick_pending}, 8'h00);
        expect_regs(56'h80_00_00_01_00_01_00);
    endtask

    task automatic t_layout();
        logic [7:0] v;
        set_regs(56'h59_d9_e3_f1_fe_f2_99);
        u_rtd_host_model.write_byte(8'h09, 8'h5a);
        expect_regs(56'h59_59_23_31_06_92_99);
        u_rtd_host_model.read_byte(8'h09, v);
        check("unmapped", v, RTD_RD_NONE);
        pulse(P_TICK);
        expect_regs(56'h00_00_00_01_00_01_00);
    endtask

    task automatic t_calendar();
        logic [55:0] st [6] = '{56'h59_59_23_28_02_02_03, 56'h59_59_23_28_02_02_04,
            56'h59_59_23_28_02_02_00, 56'h59_59_23_29_02_02_04,
            56'h59_59_23_30_04_09_10, 56'h09_00_00_31_05_01_07};
        logic [55:0] ex [6] = '{56'h00_00_00_01_03_03_03, 56'h00_00_00_29_03_02_04,
            56'h00_00_00_29_03_02_00, 56'h00_00_00_01_03_03_04,
            56'h00_00_00_01_05_10_10, 56'h10_00_00_31_05_01_07};
        for (int i = 0; i < 6; i++) begin
            set_regs(st[i]);
            pulse(P_TICK);
            expect_regs(ex[i]);
        end
    endtask

    task automatic t_flag();
        u_rtd_host_model.write_byte(RTD_ADDR_SEC, 8'h00);
        repeat (2) @(posedge clk);
        check("flag clear", {7'h0, time_out.flag}, 8'h00);
        pulse(P_TICK);
        check("flag kept", {7'h0, time_out.flag}, 8'h00);
        pulse(P_LOW);
        check("flag low", {7'h0, time_out.flag}, 8'h01);
        pulse(P_TICK);
        check("flag stays", {7'h0, time_out.flag}, 8'h01);
        u_rtd_host_model.write_byte(RTD_ADDR_SEC, 8'h00);
        @(posedge clk);
        check("flag reclear", {7'h0, time_out.flag}, 8'h00);
        pulse(P_OSC);
        check("flag osc", {7'h0, time_out.flag}, 8'h01);
        // monitor and clearing write on one edge: the set wins
        supply_low <= 1'b1;
        u_rtd_host_model.write_byte(RTD_ADDR_SEC, 8'h00);
        supply_low <= 1'b0;
        @(posedge clk);
        check("flag set wins", {7'h0, time_out.flag}, 8'h01);
    endtask

    task automatic t_freeze();
        set_regs(56'h10_00_00_01_00_01_00);
        u_rtd_host_model.idle_cycles = 3;
        u_rtd_host_model.open_access();
        pulse(P_TICK);
        pulse(P_TICK);
        check("frozen sec", {1'b0, time_out.sec}, 8'h10);
        check("queued", {7'h0, tick_pending}, 8'h01);
        u_rtd_host_model.close_access();
        repeat (3) @(posedge clk);
        check("one step", {1'b0, time_out.sec}, 8'h11);
        check("drained", {7'h0, tick_pending}, 8'h00);
        u_rtd_host_model.idle_cycles = 0;
        // tick on the last busy edge, counted at the first idle one
        u_rtd_host_model.open_access();
        @(posedge clk);
        tick_1hz <= 1'b1;
        u_rtd_host_model.close_access();
        tick_1hz <= 1'b0;
        @(posedge clk);
        check("pend edge", {7'h0, tick_pending}, 8'h01);
        @(posedge clk);
        check("late step", {1'b0, time_out.sec}, 8'h12);
        check("late drain", {7'h0, tick_pending}, 8'h00);
    endtask

    // reset in mid-run brings back the start-up values
    task automatic t_rerun();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        check("pending rst", {7'h0, tick_pending}, 8'h00);
        expect_regs(56'h80_00_00_01_00_01_00);
    endtask

    initial begin
        #200_000;
        fail_count++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_layout();
        t_calendar();
        t_flag();
        t_freeze();
        t_rerun();
        results();
    end
endmodule

// >>> core/rtd_pkg.sv
// constants, field layouts and carrier types of the time and date register set
package rtd_pkg;
    // register addresses
    localparam logic [7:0] RTD_ADDR_SEC  = 8'h02;
    localparam logic [7:0] RTD_ADDR_MIN  = 8'h03;
    localparam logic [7:0] RTD_ADDR_HOUR = 8'h04;
    localparam logic [7:0] RTD_ADDR_DAY  = 8'h05;
    localparam logic [7:0] RTD_ADDR_WDAY = 8'h06;
    localparam logic [7:0] RTD_ADDR_MON  = 8'h07;
    localparam logic [7:0] RTD_ADDR_YEAR = 8'h08;
    localparam logic [7:0] RTD_RD_NONE   = 8'h00;
    // flag bit position inside its byte
    localparam int         RTD_FLAG_BIT  = 7;
    // bcd limits
    localparam logic [7:0] RTD_SEC_LAST  = 8'h59;
    localparam logic [7:0] RTD_MIN_LAST  = 8'h59;
    localparam logic [7:0] RTD_HOUR_LAST = 8'h23;
    localparam logic [7:0] RTD_MON_LAST  = 8'h12;
    localparam logic [7:0] RTD_YEAR_LAST = 8'h99;
    localparam logic [7:0] RTD_ZERO      = 8'h00;
    localparam logic [7:0] RTD_ONE       = 8'h01;
    localparam logic [3:0] RTD_NINE      = 4'h9;
    localparam logic [3:0] RTD_DIGIT_ONE = 4'h1;
    localparam logic [3:0] RTD_DIGIT_ZERO = 4'h0;
    localparam logic [2:0] RTD_WDAY_LAST = 3'h6;
    localparam logic [2:0] RTD_WDAY_FIRST = 3'h0;
    localparam logic [2:0] RTD_WDAY_STEP = 3'h1;
    // month lengths
    localparam logic [7:0] RTD_FEB       = 8'h02;
    localparam logic [7:0] RTD_APR       = 8'h04;
    localparam logic [7:0] RTD_JUN       = 8'h06;
    localparam logic [7:0] RTD_SEP       = 8'h09;
    localparam logic [7:0] RTD_NOV       = 8'h11;
    localparam logic [7:0] RTD_DAYS_28   = 8'h28;
    localparam logic [7:0] RTD_DAYS_29   = 8'h29;
    localparam logic [7:0] RTD_DAYS_30   = 8'h30;
    localparam logic [7:0] RTD_DAYS_31   = 8'h31;
    localparam logic [1:0] RTD_LEAP_REM  = 2'h0;

    typedef struct packed {
        logic       busy;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtd_req_s;

    typedef struct packed {
        logic       flag;
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [5:0] day;
        logic [2:0] wday;
        logic       cent;
        logic [4:0] mon;
        logic [7:0] year;
    } rtd_time_s;

    localparam rtd_time_s RTD_TIME_RST = '{flag: 1'b1, sec: 7'h00, min: 7'h00,
        hour: 6'h00, day: 6'h01, wday: 3'h0, cent: 1'b0, mon: 5'h01, year: 8'h00};

    typedef enum logic [0:0] {
        RTD_IDLE = 1'b0,
        RTD_PEND = 1'b1
    } rtd_tick_e;
endpackage

// >>> core/rtd_time_date_regs.sv
// time and date register set with integrity flag, bcd calendar and frozen access
`timescale 1ns/1ps
module rtd_time_date_regs (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // register access from the serial slave
    input  wire rtd_pkg::rtd_req_s req,
    // time base and monitors
    input  wire logic             tick_1hz,
    input  wire logic             supply_low,
    input  wire logic             osc_stopped,
    // answers
    output logic [7:0]            rd_data,
    output rtd_pkg::rtd_time_s    time_out,
    output logic                  tick_pending
);
    import rtd_pkg::*;

    rtd_time_s t_q;
    rtd_time_s t_d;
    rtd_tick_e st_q;
    rtd_tick_e st_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;
    logic       inc;
    logic [8:0] r_sec;
    logic [8:0] r_min;
    logic [8:0] r_hour;
    logic [8:0] r_day;
    logic [8:0] r_mon;
    logic [8:0] r_year;
    logic [7:0] day_last;

    // bcd step: {wrap, next}
    function automatic logic [8:0] bcd_inc(
        input logic [7:0] v,
        input logic [7:0] last,
        input logic [7:0] first
    );
        logic [8:0] r;
        logic [3:0] hi;
        logic [3:0] lo;
        hi = v[7:4] + RTD_DIGIT_ONE;
        lo = v[3:0] + RTD_DIGIT_ONE;
        if (v == last) begin
            r = {1'b1, first};
        end else if (v[3:0] == RTD_NINE) begin
            r = {1'b0, hi, RTD_DIGIT_ZERO};
        end else begin
            r = {1'b0, v[7:4], lo};
        end
        return r;
    endfunction

    // last day of a bcd month
    function automatic logic [7:0] month_last(
        input logic [7:0] mon,
        input logic [7:0] year
    );
        logic [7:0] d;
        logic [1:0] rem;
        // ten is 2 mod 4, so year mod 4 comes from three bits, year[1:0] and year[4]
        rem = year[1:0] + {year[4], 1'b0};
        if (mon == RTD_FEB) begin
            d = (rem == RTD_LEAP_REM) ? RTD_DAYS_29 : RTD_DAYS_28;
        end else if (mon == RTD_APR || mon == RTD_JUN ||
                     mon == RTD_SEP || mon == RTD_NOV) begin
            d = RTD_DAYS_30;
        end else begin
            d = RTD_DAYS_31;
        end
        return d;
    endfunction

    // carry chain candidates
    assign day_last = month_last({3'h0, t_q.mon}, t_q.year);
    assign r_sec    = bcd_inc({1'b0, t_q.sec}, RTD_SEC_LAST, RTD_ZERO);
    assign r_min    = bcd_inc({1'b0, t_q.min}, RTD_MIN_LAST, RTD_ZERO);
    assign r_hour   = bcd_inc({2'h0, t_q.hour}, RTD_HOUR_LAST, RTD_ZERO);
    assign r_day    = bcd_inc({2'h0, t_q.day}, day_last, RTD_ONE);
    assign r_mon    = bcd_inc({3'h0, t_q.mon}, RTD_MON_LAST, RTD_ONE);
    assign r_year   = bcd_inc(t_q.year, RTD_YEAR_LAST, RTD_ZERO);

    // a tick counts now only outside an access
    assign inc = !req.busy && (tick_1hz || st_q == RTD_PEND);

    // tick queue
    always_comb begin
        st_d = st_q;
        case (st_q)
            RTD_IDLE: begin
                if (tick_1hz && req.busy) begin
                    st_d = RTD_PEND;
                end
            end
            RTD_PEND: begin
                // a second tick during the access is lost
                if (!req.busy && !tick_1hz) begin
                    st_d = RTD_IDLE;
                end
            end
            default: begin
                st_d = RTD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= RTD_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // time and date next value
    always_comb begin
        t_d = t_q;
        if (inc) begin
            t_d.sec = r_sec[6:0];
            if (r_sec[8]) begin
                t_d.min = r_min[6:0];
                if (r_min[8]) begin
                    t_d.hour = r_hour[5:0];
                    if (r_hour[8]) begin
                        t_d.day = r_day[5:0];
                        if (t_q.wday == RTD_WDAY_LAST) begin
                            t_d.wday = RTD_WDAY_FIRST;
                        end else begin
                            t_d.wday = t_q.wday + RTD_WDAY_STEP;
                        end
                        if (r_day[8]) begin
                            t_d.mon = r_mon[4:0];
                            if (r_mon[8]) begin
                                t_d.year = r_year[7:0];
                                if (r_year[8]) begin
                                    t_d.cent = !t_q.cent;
                                end
                            end
                        end
                    end
                end
            end
        end
        if (req.wr) begin
            case (req.addr)
                RTD_ADDR_SEC: begin
                    t_d.flag = req.wdata[RTD_FLAG_BIT];
                    t_d.sec  = req.wdata[6:0];
                end
                RTD_ADDR_MIN: begin
                    t_d.min = req.wdata[6:0];
                end
                RTD_ADDR_HOUR: begin
                    t_d.hour = req.wdata[5:0];
                end
                RTD_ADDR_DAY: begin
                    t_d.day = req.wdata[5:0];
                end
                RTD_ADDR_WDAY: begin
                    t_d.wday = req.wdata[2:0];
                end
                RTD_ADDR_MON: begin
                    t_d.cent = req.wdata[RTD_FLAG_BIT];
                    t_d.mon  = req.wdata[4:0];
                end
                RTD_ADDR_YEAR: begin
                    t_d.year = req.wdata;
                end
                default: begin
                    t_d.flag = t_d.flag;
                end
            endcase
        end
        // set wins over a clearing write
        if (supply_low || osc_stopped) begin
            t_d.flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            t_q <= RTD_TIME_RST;
        end else begin
            t_q <= t_d;
        end
    end

    // read path, unused bits zero
    always_comb begin
        rd_d = rd_q;
        if (req.rd) begin
            case (req.addr)
                RTD_ADDR_SEC: begin
                    rd_d = {t_q.flag, t_q.sec};
                end
                RTD_ADDR_MIN: begin
                    rd_d = {1'b0, t_q.min};
                end
                RTD_ADDR_HOUR: begin
                    rd_d = {2'h0, t_q.hour};
                end
                RTD_ADDR_DAY: begin
                    rd_d = {2'h0, t_q.day};
                end
                RTD_ADDR_WDAY: begin
                    rd_d = {5'h00, t_q.wday};
                end
                RTD_ADDR_MON: begin
                    rd_d = {t_q.cent, 2'h0, t_q.mon};
                end
                RTD_ADDR_YEAR: begin
                    rd_d = t_q.year;
                end
                default: begin
                    rd_d = RTD_RD_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q <= RTD_RD_NONE;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign rd_data      = rd_q;
    assign time_out     = t_q;
    assign tick_pending = (st_q == RTD_PEND);

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_flag_set;
        (supply_low || osc_stopped) |=> t_q.flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("integrity flag not set by monitor");

    property p_flag_hold;
        t_q.flag && !(req.wr && req.addr == RTD_ADDR_SEC) |=> t_q.flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("integrity flag cleared without a write");

    property p_freeze;
        req.busy && !req.wr |=> $stable(t_q.sec) && $stable(t_q.min) &&
            $stable(t_q.hour) && $stable(t_q.day) && $stable(t_q.mon) &&
            $stable(t_q.year);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("time counted during an access");

    property p_queue;
        req.busy && tick_1hz ##1 !req.busy && !req.wr |=> $changed(t_q.sec);
    endproperty
    a_queue: assert property (p_queue)
        else $error("queued tick not serviced after access");

    property p_pend_clear;
        st_q == RTD_PEND && !req.busy && !tick_1hz |=> st_q == RTD_IDLE;
    endproperty
    a_pend_clear: assert property (p_pend_clear)
        else $error("tick queue not emptied");

    property p_sec_wrap;
        inc && !req.wr && t_q.sec == RTD_SEC_LAST[6:0]
            |=> t_q.sec == RTD_ZERO[6:0] && t_q.min != $past(t_q.min);
    endproperty
    a_sec_wrap: assert property (p_sec_wrap)
        else $error("seconds wrap did not carry");

    property p_century;
        inc && !req.wr && r_sec[8] && r_min[8] && r_hour[8] && r_day[8] &&
            r_mon[8] && r_year[8] |=> t_q.cent != $past(t_q.cent) &&
            t_q.year == RTD_ZERO;
    endproperty
    a_century: assert property (p_century)
        else $error("century not toggled at year wrap");

    property p_wday;
        inc && !req.wr && r_sec[8] && r_min[8] && r_hour[8] &&
            t_q.wday == RTD_WDAY_LAST |=> t_q.wday == RTD_WDAY_FIRST;
    endproperty
    a_wday: assert property (p_wday)
        else $error("weekday did not wrap to zero");

    property p_leap;
        inc && !req.wr && r_sec[8] && r_min[8] && r_hour[8] &&
            t_q.mon == RTD_FEB[4:0] && t_q.day == RTD_DAYS_28[5:0] &&
            t_q.year == RTD_ZERO |=> t_q.day == RTD_DAYS_29[5:0];
    endproperty
    a_leap: assert property (p_leap)
        else $error("year 00 february lost day 29");

    property p_unused_rd;
        req.rd && req.addr == RTD_ADDR_HOUR |=> rd_data[7:6] == 2'h0 &&
            rd_data[5:0] == $past(t_q.hour);
    endproperty
    a_unused_rd: assert property (p_unused_rd)
        else $error("hour read wrong or unused bits set");

    c_century:   cover property (inc && r_year[8] && r_mon[8] && r_day[8]);
    c_queued:    cover property (req.busy && tick_1hz ##1 !req.busy);
    c_flag_clr:  cover property (t_q.flag ##1 !t_q.flag);
    c_leap_day:  cover property (t_q.mon == RTD_FEB[4:0] && t_q.day == RTD_DAYS_29[5:0]);
endmodule
